// ---- pkg/fsr_pkg.sv ----
package fsr_pkg;

    // Geometry of the history chain and the power stage
    localparam int HIST_DEPTH   = 10;
    localparam int PHASE_COUNT  = 15;
    localparam int ADDR_WIDTH   = 10;
    localparam int DATA_WIDTH   = 16;

    // History block: four words per entry, newest entry first
    localparam logic [9:0] ADDR_HIST_BASE   = 10'h032;  // Newest fault code
    localparam logic [9:0] ADDR_HIST_LAST   = 10'h059;  // Oldest fault time
    localparam logic [1:0] FIELD_CODE       = 2'h0;
    localparam logic [1:0] FIELD_DAY_MONTH  = 2'h1;
    localparam logic [1:0] FIELD_YEAR       = 2'h2;
    localparam logic [1:0] FIELD_TIME       = 2'h3;

    // Snapshot of the newest fault
    localparam logic [9:0] ADDR_SNAP_CURRENT  = 10'h05A;
    localparam logic [9:0] ADDR_SNAP_DC_LINK  = 10'h05B;
    localparam logic [9:0] ADDR_SNAP_SPEED    = 10'h05C;
    localparam logic [9:0] ADDR_SNAP_SPEED_REF = 10'h05D;
    localparam logic [9:0] ADDR_SNAP_FREQ     = 10'h05E;
    localparam logic [9:0] ADDR_SNAP_MOTOR_V  = 10'h05F;
    localparam logic [9:0] ADDR_SNAP_INPUTS   = 10'h060;
    localparam logic [9:0] ADDR_SNAP_OUTPUTS  = 10'h061;

    // Control and status words
    localparam logic [9:0] ADDR_CONTROL       = 10'h062;
    localparam logic [9:0] ADDR_STATUS        = 10'h063;

    // Per-phase power switch readings
    localparam logic [9:0] ADDR_TEMP_BASE     = 10'h320;
    localparam logic [9:0] ADDR_CURRENT_BASE  = 10'h32F;

    // Control word layout and reset value
    localparam int CTRL_CAPTURE_EN_BIT = 0;
    localparam int CTRL_CLEAR_BIT      = 1;
    localparam logic [15:0] CONTROL_RESET = 16'h0001;

    // Upper limits of recorded fields, and both ends of the phase current range
    localparam logic [7:0]  MAX_DAY      = 8'h1F;
    localparam logic [7:0]  MAX_MONTH    = 8'h0C;
    localparam logic [7:0]  MAX_YEAR     = 8'h63;
    localparam logic [7:0]  MAX_HOUR     = 8'h17;
    localparam logic [7:0]  MAX_MINUTE   = 8'h3B;
    localparam logic [9:0]  MAX_CODE     = 10'h3E7;
    localparam logic [15:0] MAX_CURRENT  = 16'hAFC8;
    localparam logic [15:0] MAX_VOLTS    = 16'h07D0;
    localparam logic [15:0] MAX_SPEED    = 16'h4650;
    localparam logic [15:0] MAX_FREQ     = 16'h27D8;
    localparam logic signed [15:0] MIN_PHASE_CURRENT = 16'shD8F0;
    localparam logic signed [15:0] MAX_PHASE_CURRENT = 16'sh4E20;

    // Calendar clock reading
    typedef struct packed {
        logic [7:0] day;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] hour;
        logic [7:0] minute;
    } fsr_stamp_t;

    // Live drive values sampled at a fault
    typedef struct packed {
        logic [15:0] outCurrent;
        logic [15:0] dcLinkVolts;
        logic [15:0] motorSpeed;
        logic [15:0] speedRef;
        logic [15:0] outFreq;
        logic [15:0] motorVolts;
        logic [7:0]  digitalInputN;
        logic [4:0]  digitalOutputN;
    } fsr_sample_t;

    // One entry of the history chain
    typedef struct packed {
        logic [9:0]  code;
        logic [15:0] dayMonth;
        logic [15:0] year;
        logic [15:0] time_;
    } fsr_entry_t;

endpackage : fsr_pkg

// ---- verilog/fsr_recorder.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsr_recorder #(
    parameter int HIST_DEPTH  = fsr_pkg::HIST_DEPTH,
    parameter int PHASE_COUNT = fsr_pkg::PHASE_COUNT
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // Register port
    input  wire logic [9:0]                 address,
    input  wire logic [15:0]                writeData,
    input  wire logic                       writeStrobe,
    input  wire logic                       readStrobe,
    output logic      [15:0]                readData,
    // Fault event from the protection logic
    input  wire logic                       faultStrobe,
    input  wire logic [9:0]                 faultCode,
    // Calendar clock and live drive values
    input  wire fsr_pkg::fsr_stamp_t        stamp,
    input  wire fsr_pkg::fsr_sample_t       sample,
    // Power stage measurements
    input  wire logic [PHASE_COUNT-1:0][15:0] switchTemp,
    input  wire logic [PHASE_COUNT-1:0][15:0] switchCurrent
);

    logic [9:0]  histCode_reg     [HIST_DEPTH];
    logic [15:0] histDayMonth_reg [HIST_DEPTH];
    logic [15:0] histYear_reg     [HIST_DEPTH];
    logic [15:0] histTime_reg     [HIST_DEPTH];
    fsr_pkg::fsr_entry_t  newEntry;
    fsr_pkg::fsr_sample_t snapNext;
    logic [15:0] snapCurrent_reg;
    logic [15:0] snapDcLink_reg;
    logic [15:0] snapSpeed_reg;
    logic [15:0] snapSpeedRef_reg;
    logic [15:0] snapFreq_reg;
    logic [15:0] snapMotorV_reg;
    logic [7:0]  snapInputs_reg;
    logic [4:0]  snapOutputs_reg;
    logic [15:0] control_reg;
    logic [3:0]  count_reg;
    logic [15:0] readData_reg;
    logic [15:0] readData_next;
    logic        captureEn;
    logic        clearReq;
    logic        takeFault;

    // Unsigned saturation to an upper limit
    function automatic logic [15:0] clampU(input logic [15:0] v,
                                           input logic [15:0] lim);
        clampU = (v > lim) ? lim : v;
    endfunction : clampU

    // Byte-wide saturation for calendar fields
    function automatic logic [7:0] clampB(input logic [7:0] v,
                                          input logic [7:0] lim);
        clampB = (v > lim) ? lim : v;
    endfunction : clampB

    // Signed saturation for phase currents
    function automatic logic [15:0] clampS(input logic signed [15:0] v);
        if (v < fsr_pkg::MIN_PHASE_CURRENT) begin
            clampS = fsr_pkg::MIN_PHASE_CURRENT;
        end else if (v > fsr_pkg::MAX_PHASE_CURRENT) begin
            clampS = fsr_pkg::MAX_PHASE_CURRENT;
        end else begin
            clampS = v;
        end
    endfunction : clampS

    assign captureEn = control_reg[fsr_pkg::CTRL_CAPTURE_EN_BIT];
    assign clearReq  = writeStrobe && (address == fsr_pkg::ADDR_CONTROL)
                       && writeData[fsr_pkg::CTRL_CLEAR_BIT];
    assign takeFault = faultStrobe && captureEn;

    // Newest entry built from the live calendar, saturated into range
    always_comb begin
        newEntry.code     = (faultCode > fsr_pkg::MAX_CODE) ?
                            fsr_pkg::MAX_CODE : faultCode;
        newEntry.dayMonth = {clampB(stamp.day, fsr_pkg::MAX_DAY),
                             clampB(stamp.month, fsr_pkg::MAX_MONTH)};
        newEntry.year     = {8'h00,
                             clampB(stamp.year, fsr_pkg::MAX_YEAR)};
        newEntry.time_    = {clampB(stamp.hour, fsr_pkg::MAX_HOUR),
                             clampB(stamp.minute,
                                    fsr_pkg::MAX_MINUTE)};
    end

    // Snapshot of the drive values, saturated into range
    always_comb begin
        snapNext.outCurrent  = clampU(sample.outCurrent,
                                      fsr_pkg::MAX_CURRENT);
        snapNext.dcLinkVolts = clampU(sample.dcLinkVolts,
                                      fsr_pkg::MAX_VOLTS);
        snapNext.motorSpeed  = clampU(sample.motorSpeed,
                                      fsr_pkg::MAX_SPEED);
        snapNext.speedRef    = clampU(sample.speedRef,
                                      fsr_pkg::MAX_SPEED);
        snapNext.outFreq     = clampU(sample.outFreq,
                                      fsr_pkg::MAX_FREQ);
        snapNext.motorVolts  = clampU(sample.motorVolts,
                                      fsr_pkg::MAX_VOLTS);
        snapNext.digitalInputN  = sample.digitalInputN;
        snapNext.digitalOutputN = sample.digitalOutputN;
    end

    // Code chain: a fault shifts one place and wins over a clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                histCode_reg[i] <= '0;
            end
        end else if (takeFault) begin
            histCode_reg[0] <= newEntry.code;
            for (int i = 1; i < HIST_DEPTH; i++) begin
                histCode_reg[i] <= histCode_reg[i-1];
            end
        end else if (clearReq) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                histCode_reg[i] <= '0;
            end
        end
    end

    // Day and month chain, shifted with the codes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                histDayMonth_reg[i] <= '0;
            end
        end else if (takeFault) begin
            histDayMonth_reg[0] <= newEntry.dayMonth;
            for (int i = 1; i < HIST_DEPTH; i++) begin
                histDayMonth_reg[i] <= histDayMonth_reg[i-1];
            end
        end else if (clearReq) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                histDayMonth_reg[i] <= '0;
            end
        end
    end

    // Year chain, shifted with the codes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                histYear_reg[i] <= '0;
            end
        end else if (takeFault) begin
            histYear_reg[0] <= newEntry.year;
            for (int i = 1; i < HIST_DEPTH; i++) begin
                histYear_reg[i] <= histYear_reg[i-1];
            end
        end else if (clearReq) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                histYear_reg[i] <= '0;
            end
        end
    end

    // Hour and minute chain, shifted with the codes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                histTime_reg[i] <= '0;
            end
        end else if (takeFault) begin
            histTime_reg[0] <= newEntry.time_;
            for (int i = 1; i < HIST_DEPTH; i++) begin
                histTime_reg[i] <= histTime_reg[i-1];
            end
        end else if (clearReq) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                histTime_reg[i] <= '0;
            end
        end
    end

    // Output current loads in the fault cycle, holds until the next fault or a clear.
    // A fault in the reset cycle itself is lost; values then stay zero.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snapCurrent_reg <= '0;
        end else if (takeFault) begin
            snapCurrent_reg <= snapNext.outCurrent;
        end else if (clearReq) begin
            snapCurrent_reg <= '0;
        end
    end

    // DC link voltage at the fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snapDcLink_reg <= '0;
        end else if (takeFault) begin
            snapDcLink_reg <= snapNext.dcLinkVolts;
        end else if (clearReq) begin
            snapDcLink_reg <= '0;
        end
    end

    // Motor speed at the fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snapSpeed_reg <= '0;
        end else if (takeFault) begin
            snapSpeed_reg <= snapNext.motorSpeed;
        end else if (clearReq) begin
            snapSpeed_reg <= '0;
        end
    end

    // Speed reference at the fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snapSpeedRef_reg <= '0;
        end else if (takeFault) begin
            snapSpeedRef_reg <= snapNext.speedRef;
        end else if (clearReq) begin
            snapSpeedRef_reg <= '0;
        end
    end

    // Output frequency at the fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snapFreq_reg <= '0;
        end else if (takeFault) begin
            snapFreq_reg <= snapNext.outFreq;
        end else if (clearReq) begin
            snapFreq_reg <= '0;
        end
    end

    // Motor voltage at the fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snapMotorV_reg <= '0;
        end else if (takeFault) begin
            snapMotorV_reg <= snapNext.motorVolts;
        end else if (clearReq) begin
            snapMotorV_reg <= '0;
        end
    end

    // Digital input states at the fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snapInputs_reg <= '0;
        end else if (takeFault) begin
            snapInputs_reg <= snapNext.digitalInputN;
        end else if (clearReq) begin
            snapInputs_reg <= '0;
        end
    end

    // Digital output states at the fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snapOutputs_reg <= '0;
        end else if (takeFault) begin
            snapOutputs_reg <= snapNext.digitalOutputN;
        end else if (clearReq) begin
            snapOutputs_reg <= '0;
        end
    end

    // Number of valid entries, saturating at the chain depth
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_reg <= 4'h0;
        end else if (takeFault) begin
            if (count_reg != 4'(HIST_DEPTH)) begin
                count_reg <= count_reg + 4'h1;
            end
        end else if (clearReq) begin
            count_reg <= 4'h0;
        end
    end

    // Control word is the only writable location; clear bit self-clears
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            control_reg <= fsr_pkg::CONTROL_RESET;
        end else if (writeStrobe && address == fsr_pkg::ADDR_CONTROL) begin
            control_reg <= {15'h0000,
                            writeData[fsr_pkg::CTRL_CAPTURE_EN_BIT]};
        end
    end

    // Read decode; every other write falls through untouched
    always_comb begin
        logic [9:0] rel;
        logic [3:0] idx;
        rel = 10'h000;
        idx = 4'h0;
        readData_next = 16'h0000;
        if (readStrobe) begin
            if (address >= fsr_pkg::ADDR_HIST_BASE &&
                address <= fsr_pkg::ADDR_HIST_LAST) begin
                rel = address - fsr_pkg::ADDR_HIST_BASE;
                idx = rel[5:2];
                unique case (rel[1:0])
                    fsr_pkg::FIELD_CODE:
                        readData_next = {6'h00, histCode_reg[idx]};
                    fsr_pkg::FIELD_DAY_MONTH:
                        readData_next = histDayMonth_reg[idx];
                    fsr_pkg::FIELD_YEAR:
                        readData_next = histYear_reg[idx];
                    fsr_pkg::FIELD_TIME:
                        readData_next = histTime_reg[idx];
                endcase
            end else if (address >= fsr_pkg::ADDR_TEMP_BASE &&
                         address < fsr_pkg::ADDR_CURRENT_BASE) begin
                rel = address - fsr_pkg::ADDR_TEMP_BASE;
                readData_next = switchTemp[rel[3:0]];
            end else if (address >= fsr_pkg::ADDR_CURRENT_BASE &&
                         address < fsr_pkg::ADDR_CURRENT_BASE
                                   + 10'(PHASE_COUNT)) begin
                rel = address - fsr_pkg::ADDR_CURRENT_BASE;
                readData_next = clampS(switchCurrent[rel[3:0]]);
            end else begin
                unique case (address)
                    fsr_pkg::ADDR_SNAP_CURRENT:
                        readData_next = snapCurrent_reg;
                    fsr_pkg::ADDR_SNAP_DC_LINK:
                        readData_next = snapDcLink_reg;
                    fsr_pkg::ADDR_SNAP_SPEED:
                        readData_next = snapSpeed_reg;
                    fsr_pkg::ADDR_SNAP_SPEED_REF:
                        readData_next = snapSpeedRef_reg;
                    fsr_pkg::ADDR_SNAP_FREQ:
                        readData_next = snapFreq_reg;
                    fsr_pkg::ADDR_SNAP_MOTOR_V:
                        readData_next = snapMotorV_reg;
                    fsr_pkg::ADDR_SNAP_INPUTS:
                        readData_next = {8'h00,
                                         snapInputs_reg};
                    fsr_pkg::ADDR_SNAP_OUTPUTS:
                        readData_next = {11'h000,
                                         snapOutputs_reg};
                    fsr_pkg::ADDR_CONTROL:
                        readData_next = control_reg;
                    fsr_pkg::ADDR_STATUS:
                        readData_next = {12'h000, count_reg};
                    default:
                        readData_next = 16'h0000;
                endcase
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            readData_reg <= 16'h0000;
        end else begin
            readData_reg <= readData_next;
        end
    end

    assign readData = readData_reg;

endmodule : fsr_recorder

`default_nettype wire

// ---- test/fsr_recorder_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsr_recorder_sva #(
    parameter int HIST_DEPTH  = 10,
    parameter int PHASE_COUNT = 15
) (
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          reset_n,
    // Register port
    input wire logic [9:0]                    address,
    input wire logic [15:0]                   writeData,
    input wire logic                          writeStrobe,
    input wire logic                          readStrobe,
    input wire logic [15:0]                   readData,
    // Fault event and live values
    input wire logic                          faultStrobe,
    input wire logic [9:0]                    faultCode,
    input wire fsr_pkg::fsr_stamp_t           stamp,
    input wire fsr_pkg::fsr_sample_t          sample,
    input wire logic [PHASE_COUNT-1:0][15:0]  switchTemp,
    input wire logic [PHASE_COUNT-1:0][15:0]  switchCurrent
);
    // Mirror of capture enable, so fault checks skip refused faults
    logic capEn_reg;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            capEn_reg <= 1'b1;
        end else if (writeStrobe && address == fsr_pkg::ADDR_CONTROL) begin
            capEn_reg <= writeData[fsr_pkg::CTRL_CAPTURE_EN_BIT];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Read data stands only in the cycle after a read
    AST_IDLE_ZERO: assert property (!readStrobe |=> readData == 16'h0000)
        else $error("read data not zero outside a read answer");
    AST_DAY_MONTH: assert property (
        readStrobe && address >= 10'h033 && address <= 10'h057
        && address[1:0] == 2'h3 |=> readData[15:8] <= fsr_pkg::MAX_DAY
        && readData[7:0] <= fsr_pkg::MAX_MONTH)
        else $error("day or month out of range");
    AST_YEAR: assert property (
        readStrobe && address >= 10'h034 && address <= 10'h058
        && address[1:0] == 2'h0 |=> readData <= {8'h00, fsr_pkg::MAX_YEAR})
        else $error("year out of range");
    AST_TIME: assert property (
        readStrobe && address >= 10'h035 && address <= 10'h059
        && address[1:0] == 2'h1 |=> readData[15:8] <= fsr_pkg::MAX_HOUR
        && readData[7:0] <= fsr_pkg::MAX_MINUTE)
        else $error("hour or minute out of range");
    AST_SPEED_RANGE: assert property (
        readStrobe && (address == fsr_pkg::ADDR_SNAP_SPEED
        || address == fsr_pkg::ADDR_SNAP_SPEED_REF)
        |=> readData <= fsr_pkg::MAX_SPEED)
        else $error("speed word above limit");
    AST_INPUT_CAPTURE: assert property (
        faultStrobe && capEn_reg ##1 readStrobe
        && address == fsr_pkg::ADDR_SNAP_INPUTS
        |=> readData == {8'h00, $past(sample.digitalInputN, 2)})
        else $error("input bitmap not captured at fault");
    AST_OUTPUT_ZERO: assert property (
        readStrobe && address == fsr_pkg::ADDR_SNAP_OUTPUTS
        |=> readData[15:5] == 11'h000)
        else $error("output bitmap upper bits not zero");
    AST_NEWEST_CODE: assert property (
        faultStrobe && capEn_reg ##1 readStrobe
        && address == fsr_pkg::ADDR_HIST_BASE |=> readData == {6'h00,
        (($past(faultCode, 2) > fsr_pkg::MAX_CODE) ? fsr_pkg::MAX_CODE
        : $past(faultCode, 2))})
        else $error("newest code not shifted in");
    AST_PHASE_CURRENT: assert property (
        readStrobe && address >= 10'h32F && address <= 10'h33D
        |=> $signed(readData) >= fsr_pkg::MIN_PHASE_CURRENT
        && $signed(readData) <= fsr_pkg::MAX_PHASE_CURRENT)
        else $error("phase current out of range");
endmodule : fsr_recorder_sva

bind fsr_recorder fsr_recorder_sva #(
    .HIST_DEPTH (HIST_DEPTH),
    .PHASE_COUNT(PHASE_COUNT)
) i_sva (
    .clk(clk), .reset_n(reset_n), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData),
    .faultStrobe(faultStrobe), .faultCode(faultCode), .stamp(stamp),
    .sample(sample), .switchTemp(switchTemp), .switchCurrent(switchCurrent)
);

`default_nettype wire

// ---- test/fsr_recorder_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsr_recorder_tb_top;
    logic                 clk;
    logic                 reset_n = 1'b0;
    logic [9:0]           address = 10'h000;
    logic [15:0]          writeData = 16'h0000;
    logic                 writeStrobe = 1'b0;
    logic                 readStrobe = 1'b0;
    logic [15:0]          readData;
    logic                 faultStrobe = 1'b0;
    logic [9:0]           faultCode = 10'h000;
    fsr_pkg::fsr_stamp_t  stamp = '0;
    fsr_pkg::fsr_sample_t sample = '0;
    logic [14:0][15:0]    switchTemp = '0;
    logic [14:0][15:0]    switchCurrent = '0;
    int                   fails = 0;
    int                   n_compared = 0;
    int                   cycles = 0;

    fsr_recorder i_dut (
        .clk(clk), .reset_n(reset_n), .address(address),
        .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData),
        .faultStrobe(faultStrobe), .faultCode(faultCode), .stamp(stamp),
        .sample(sample), .switchTemp(switchTemp),
        .switchCurrent(switchCurrent)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, far above the 150 or so cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        writeStrobe <= 1'b1;
        address <= a;
        writeData <= d;
        @(posedge clk);
        writeStrobe <= 1'b0;
    endtask : wr

    // Answer stands one cycle only, so sample just after the answer edge
    task automatic rd(input logic [9:0] a, input logic [15:0] exp,
                      input string what);
        @(posedge clk);
        readStrobe <= 1'b1;
        address <= a;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1;
        chk(what, exp, readData);
    endtask : rd

    // Fault pulse, then a read in the very next cycle
    task automatic fault(input logic [9:0] c, input logic [9:0] a);
        @(posedge clk);
        faultStrobe <= 1'b1;
        faultCode <= c;
        @(posedge clk);
        faultStrobe <= 1'b0;
        readStrobe <= 1'b1;
        address <= a;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1;
    endtask : fault

    task automatic test_snapshot();
        @(posedge clk);
        stamp <= {8'h1F, 8'h0C, 8'h63, 8'h17, 8'h3B};
        sample <= {16'h1194, 16'h07D0, 16'hFFFF, 16'h4650, 16'h27D8,
                   16'h0190, 8'hA5, 5'h1C};
        fault(10'h005, fsr_pkg::ADDR_SNAP_INPUTS);
        chk("inputs", 16'h00A5, readData);
        @(posedge clk);
        sample <= '1;
        stamp <= '0;
        wr(fsr_pkg::ADDR_SNAP_CURRENT, 16'h0000);
        rd(fsr_pkg::ADDR_SNAP_CURRENT, 16'h1194, "current");
        rd(fsr_pkg::ADDR_SNAP_DC_LINK, 16'h07D0, "dc link");
        rd(fsr_pkg::ADDR_SNAP_SPEED, 16'h4650, "speed");
        rd(fsr_pkg::ADDR_SNAP_SPEED_REF, 16'h4650, "speed ref");
        rd(fsr_pkg::ADDR_SNAP_FREQ, 16'h27D8, "freq");
        rd(fsr_pkg::ADDR_SNAP_MOTOR_V, 16'h0190, "motor volts");
        rd(fsr_pkg::ADDR_SNAP_OUTPUTS, 16'h001C, "outputs");
        rd(10'h033, 16'h1F0C, "day month");
        rd(10'h034, 16'h0063, "year");
        rd(10'h035, 16'h173B, "time");
        rd(10'h3FF, 16'h0000, "unmapped");
        $display("test_snapshot done");
    endtask : test_snapshot

    // Eleven back-to-back faults: the oldest two fall off the chain
    task automatic test_shift();
        for (int i = 1; i <= 11; i++) begin
            @(posedge clk);
            faultStrobe <= 1'b1;
            faultCode <= (i == 11) ? 10'h3FF : 10'(i);
        end
        @(posedge clk);
        faultStrobe <= 1'b0;
        readStrobe <= 1'b1;
        address <= fsr_pkg::ADDR_HIST_BASE;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1;
        chk("newest code", 16'h03E7, readData);
        for (int n = 1; n < 10; n++) begin
            rd(10'(50 + 4 * n), 16'(11 - n), "older code");
        end
        rd(fsr_pkg::ADDR_STATUS, 16'h000A, "count");
        $display("test_shift done");
    endtask : test_shift

    task automatic test_control();
        wr(fsr_pkg::ADDR_CONTROL, 16'h0000);
        fault(10'h007, fsr_pkg::ADDR_HIST_BASE);
        chk("refused fault", 16'h03E7, readData);
        wr(fsr_pkg::ADDR_CONTROL, 16'h0003);
        rd(fsr_pkg::ADDR_STATUS, 16'h0000, "cleared count");
        rd(fsr_pkg::ADDR_HIST_BASE, 16'h0000, "cleared code");
        rd(fsr_pkg::ADDR_CONTROL, 16'h0001, "control");
        $display("test_control done");
    endtask : test_control

    task automatic test_power();
        logic [15:0] expCur;
        @(posedge clk);
        for (int i = 0; i < 15; i++) begin
            switchTemp[i] <= 16'h0100 + 16'(i);
            switchCurrent[i] <= (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF
                : (i == 2) ? 16'hD8F0 : 16'(i * 256);
        end
        for (int i = 0; i < 15; i++) begin
            expCur = (i == 1) ? 16'h4E20 : (i < 3) ? 16'hD8F0 : 16'(i * 256);
            rd(fsr_pkg::ADDR_TEMP_BASE + 10'(i), 16'h0100 + 16'(i),
               "temp");
            rd(fsr_pkg::ADDR_CURRENT_BASE + 10'(i), expCur,
               "phase cur");
        end
        $display("test_power done");
    endtask : test_power

    // Reset in mid-run with a fault pending: nothing may be kept
    task automatic test_reset_fault();
        @(posedge clk);
        reset_n <= 1'b0;
        faultStrobe <= 1'b1;
        faultCode <= 10'h009;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        faultStrobe <= 1'b0;
        rd(fsr_pkg::ADDR_STATUS, 16'h0000, "count after reset");
        rd(fsr_pkg::ADDR_CONTROL, 16'h0001, "control after reset");
        rd(fsr_pkg::ADDR_SNAP_CURRENT, 16'h0000, "snap after reset");
        $display("test_reset_fault done");
    endtask : test_reset_fault

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(fsr_pkg::ADDR_CONTROL, 16'h0001, "reset control");
        rd(fsr_pkg::ADDR_HIST_BASE, 16'h0000, "reset code");
        test_snapshot();
        test_shift();
        test_control();
        test_power();
        test_reset_fault();
        final_report();
    end
endmodule : fsr_recorder_tb_top

`default_nettype wire
